// *** hdl/power_mode_reset_gating.sv ***
// power_mode_reset_gating: power-mode sequencer, reset filtering per mode,
// bus clock dividers and per-peripheral clock gates.
// assumes all inputs synchronous to clk_i and a core that pulses its
// low-power request and handler-return strobes for one cycle.
//
// Summary of operation
// - active mode keeps core and peripheral clocks running
// - sleep stops the core clock, peripherals stay clocked
// - deep sleep stops the core clock and the fast clock
// - low-power entry only from active mode on a core request
// - an interrupt returns any low-power mode to active
// - after reset and after wake the mode is active
// - low external reset pin resets in every mode
// - low supply detector reset honoured in every mode
// - register core reset acts only in active mode
// - window watchdog reset honoured in active and sleep, not deep
// - power-on, independent watchdog always; software, stall, chip reset active only
// - programmable dividers for system and peripheral bus clocks
// - per-peripheral clock gates on both bus clocks
// - wake back to active takes about three microseconds
// - request enters deep sleep when deep select is 1, else sleep
// - sleep-on-return enters selected mode after lowest handler returns
// - deep entry stops fast clock, slow clock keeps its state
// - wake from deep with wake select 1 resumes on internal fast oscillator, else prior clock
`default_nettype none
module power_mode_reset_gating #(
  parameter int unsigned GATES_W     = 16,
  parameter int unsigned DIV_W       = 8,
  parameter int unsigned WAKE_CYCLES = power_mode_pkg::WAKE_CYCLES
) (
  // clock, reset, enable
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       clk_en_i,
  // register port
  input  wire logic [power_mode_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rdata_o,
  // core side
  input  wire logic                       low_power_req_i,
  input  wire logic                       handler_return_i,
  input  wire logic                       irq_pending_i,
  // reset sources
  input  wire power_mode_pkg::reset_src_t reset_src_i,
  // clock tree and reset outputs
  output power_mode_pkg::clk_ctrl_t       clk_ctrl_o,
  output power_mode_pkg::mode_t           mode_o,
  output logic                            sys_clk_tick_o,
  output logic                            per_clk_tick_o,
  output logic      [GATES_W-1:0]         system_clock_gates_o,
  output logic      [GATES_W-1:0]         peripheral_clock_gates_o,
  output logic                            core_reset_o,
  output logic                            chip_reset_o,
  // interrupt
  output logic                            irq_o
);

  localparam int unsigned WCNT_W = $clog2(WAKE_CYCLES + 1);

  // divider tick: counter reaching the programmed value
  function automatic logic div_hit(input logic [DIV_W-1:0] cnt,
                                   input logic [DIV_W-1:0] div);
    div_hit = (cnt == div);
  endfunction

  function automatic logic [DIV_W-1:0] div_step(
    input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] div);
    div_step = div_hit(cnt, div) ? '0 : cnt + 1'b1;
  endfunction

  power_mode_pkg::mode_t mode_reg;
  power_mode_pkg::mode_t mode_next;
  logic [4:0]         ctrl_reg;
  logic [DIV_W-1:0]   sys_div_reg;
  logic [DIV_W-1:0]   per_div_reg;
  logic [DIV_W-1:0]   sys_cnt_reg;
  logic [DIV_W-1:0]   per_cnt_reg;
  logic [GATES_W-1:0] sys_gates_reg;
  logic [GATES_W-1:0] per_gates_reg;
  logic [WCNT_W-1:0]  wake_cnt_reg;
  logic [power_mode_pkg::EV_W-1:0] irq_stat_reg;
  logic [power_mode_pkg::EV_W-1:0] irq_mask_reg;
  logic [31:0]        rdata_reg;
  logic               core_rst_reg;
  logic               chip_rst_reg;
  logic               ext_src_reg;

  // register decode
  wire sel_ctrl  = addr_i == power_mode_pkg::OFF_CTRL;
  wire sel_sdiv  = addr_i == power_mode_pkg::OFF_SYS_DIV;
  wire sel_pdiv  = addr_i == power_mode_pkg::OFF_PER_DIV;
  wire sel_sgate = addr_i == power_mode_pkg::OFF_SYS_GATES;
  wire sel_pgate = addr_i == power_mode_pkg::OFF_PER_GATES;
  wire sel_cmd   = addr_i == power_mode_pkg::OFF_RESET_CMD;
  wire sel_stat  = addr_i == power_mode_pkg::OFF_STATUS;
  wire sel_istat = addr_i == power_mode_pkg::OFF_IRQ_STAT;
  wire sel_imask = addr_i == power_mode_pkg::OFF_IRQ_MASK;

  wire wr_cmd    = wr_i && sel_cmd;
  wire is_active = mode_reg == power_mode_pkg::MODE_ACTIVE;
  wire is_sleep  = mode_reg == power_mode_pkg::MODE_SLEEP;
  wire is_deep   = mode_reg == power_mode_pkg::MODE_DEEP;
  wire is_low    = is_sleep || is_deep;

  // core requests: immediate, or on return from the lowest handler
  wire enter_req = low_power_req_i ||
                   (handler_return_i &&
                    ctrl_reg[power_mode_pkg::CTRL_ON_RET]);
  wire enter_ok  = is_active && enter_req;
  wire to_deep   = ctrl_reg[power_mode_pkg::CTRL_DEEP];
  wire wake_done = wake_cnt_reg == WCNT_W'(WAKE_CYCLES - 1);

  // reset qualification per mode
  wire rst_always = !reset_src_i.ext_pin_n ||
                    reset_src_i.low_supply_detector ||
                    reset_src_i.independent_watchdog;
  wire rst_window_watchdog   = reset_src_i.window_watchdog && !is_deep;
  wire rst_active = is_active &&
                    (reset_src_i.sw_system_reset ||
                     reset_src_i.core_stall_fault ||
                     (wr_cmd &&
                      wdata_i[power_mode_pkg::CMD_CHIP_RST]));
  wire core_rst_req = is_active && wr_cmd &&
                      wdata_i[power_mode_pkg::CMD_CORE_RST];
  wire cmd_ignored  = !is_active && wr_cmd &&
                      (wdata_i[power_mode_pkg::CMD_CORE_RST] ||
                       wdata_i[power_mode_pkg::CMD_CHIP_RST]);
  wire chip_rst_req = rst_always || rst_window_watchdog || rst_active;
  wire ignored_ev   = cmd_ignored ||
                      (is_low && (reset_src_i.sw_system_reset ||
                                  reset_src_i.core_stall_fault)) ||
                      (is_deep && reset_src_i.window_watchdog);

  // hardware events for the interrupt status
  wire [power_mode_pkg::EV_W-1:0] ev;
  assign ev[power_mode_pkg::EV_SLEEP]   = enter_ok && !to_deep;
  assign ev[power_mode_pkg::EV_DEEP]    = enter_ok && to_deep;
  assign ev[power_mode_pkg::EV_WAKE]    =
    (mode_reg == power_mode_pkg::MODE_WAKE) && wake_done;
  assign ev[power_mode_pkg::EV_IGNORED] = ignored_ev;

  // mode sequencing
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      power_mode_pkg::MODE_ACTIVE:
      begin
        if (enter_ok)
          mode_next = to_deep ? power_mode_pkg::MODE_DEEP
                              : power_mode_pkg::MODE_SLEEP;
      end
      power_mode_pkg::MODE_SLEEP,
      power_mode_pkg::MODE_DEEP:
      begin
        if (irq_pending_i)
          mode_next = power_mode_pkg::MODE_WAKE;
      end
      power_mode_pkg::MODE_WAKE:
      begin
        if (wake_done)
          mode_next = power_mode_pkg::MODE_ACTIVE;
      end
      default:
        mode_next = power_mode_pkg::MODE_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_reg <= power_mode_pkg::MODE_ACTIVE;
    else if (clk_en_i)
      mode_reg <= mode_next;
  end

  // wake delay counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_cnt_reg <= '0;
    else if (clk_en_i)
      wake_cnt_reg <= (mode_reg == power_mode_pkg::MODE_WAKE)
                      ? wake_cnt_reg + 1'b1 : '0;
  end

  // clock source: wake may force the internal fast oscillator
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_src_reg <= 1'b0;
    else if (clk_en_i)
    begin
      if (is_deep && irq_pending_i &&
          ctrl_reg[power_mode_pkg::CTRL_WAKE_IFO])
        ext_src_reg <= 1'b0;
      else if (wr_i && sel_ctrl)
        ext_src_reg <= wdata_i[power_mode_pkg::CTRL_EXT_SRC];
    end
  end

  // mode control and interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg     <= power_mode_pkg::CTRL_RESET;
      irq_mask_reg <= '0;
    end
    else if (clk_en_i && wr_i)
    begin
      if (sel_ctrl)
        ctrl_reg <= wdata_i[4:0];
      if (sel_imask)
        irq_mask_reg <= wdata_i[power_mode_pkg::EV_W-1:0];
    end
  end

  // bus clock divider settings
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sys_div_reg <= DIV_W'(power_mode_pkg::DIV_RESET);
      per_div_reg <= DIV_W'(power_mode_pkg::DIV_RESET);
    end
    else if (clk_en_i && wr_i)
    begin
      if (sel_sdiv)
        sys_div_reg <= wdata_i[DIV_W-1:0];
      if (sel_pdiv)
        per_div_reg <= wdata_i[DIV_W-1:0];
    end
  end

  // per-peripheral clock gates
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sys_gates_reg <= GATES_W'(power_mode_pkg::GATES_RESET);
      per_gates_reg <= GATES_W'(power_mode_pkg::GATES_RESET);
    end
    else if (clk_en_i && wr_i)
    begin
      if (sel_sgate)
        sys_gates_reg <= wdata_i[GATES_W-1:0];
      if (sel_pgate)
        per_gates_reg <= wdata_i[GATES_W-1:0];
    end
  end

  // sticky status: set wins over write-one-to-clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_reg <= '0;
    else if (clk_en_i)
      irq_stat_reg <= (irq_stat_reg &
                       ~((wr_i && sel_istat)
                         ? wdata_i[power_mode_pkg::EV_W-1:0] : '0)) | ev;
  end

  // bus clock dividers, held while the peripheral clock is off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sys_cnt_reg <= '0;
      per_cnt_reg <= '0;
    end
    else if (clk_en_i && !is_deep)
    begin
      sys_cnt_reg <= div_step(sys_cnt_reg, sys_div_reg);
      per_cnt_reg <= div_step(per_cnt_reg, per_div_reg);
    end
  end

  // reset pulses
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_rst_reg <= 1'b0;
      chip_rst_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      core_rst_reg <= core_rst_req;
      chip_rst_reg <= chip_rst_req;
    end
  end

  // read data one cycle after the strobe
  wire [31:0] status_word = {27'h0, ext_src_reg, 1'b0,
                             mode_reg == power_mode_pkg::MODE_WAKE,
                             mode_reg};
  wire [31:0] rd_mux =
    sel_ctrl  ? {27'h0, ctrl_reg[4:1], ctrl_reg[0]} :
    sel_sdiv  ? 32'(sys_div_reg) :
    sel_pdiv  ? 32'(per_div_reg) :
    sel_sgate ? 32'(sys_gates_reg) :
    sel_pgate ? 32'(per_gates_reg) :
    sel_stat  ? status_word :
    sel_istat ? 32'(irq_stat_reg) :
    sel_imask ? 32'(irq_mask_reg) : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0000_0000;
    else if (clk_en_i)
      rdata_reg <= rd_i ? rd_mux : 32'h0000_0000;
  end

  // clock gating from the mode
  wire run_periph = !is_deep;
  assign clk_ctrl_o.core_clk_en   = is_active;
  assign clk_ctrl_o.periph_clk_en = run_periph;
  assign clk_ctrl_o.fast_clk_en   = !is_deep;
  assign clk_ctrl_o.slow_clk_en   =
    ctrl_reg[power_mode_pkg::CTRL_SLOW_EN];
  assign clk_ctrl_o.fast_src_ext  = ext_src_reg;
  assign mode_o                   = mode_reg;

  assign sys_clk_tick_o = run_periph &&
                          div_hit(sys_cnt_reg, sys_div_reg);
  assign per_clk_tick_o = run_periph &&
                          div_hit(per_cnt_reg, per_div_reg);
  assign system_clock_gates_o     =
    run_periph ? sys_gates_reg : '0;
  assign peripheral_clock_gates_o =
    run_periph ? per_gates_reg : '0;

  assign core_reset_o = core_rst_reg;
  assign chip_reset_o = chip_rst_reg;
  assign rdata_o      = rdata_reg;
  assign irq_o        = |(irq_stat_reg & irq_mask_reg);

endmodule
`default_nettype wire

// *** hdl/power_mode_pkg.sv ***
// power_mode_pkg: constants, modes and carrier types of the power-mode
// controller; assumes a 40 MHz system clock and a plain register port.
`default_nettype none
package power_mode_pkg;

  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned WAKE_TIME_NS = 3_000;
  // longest time, so round down
  localparam int unsigned WAKE_CYCLES  =
    (WAKE_TIME_NS * (CLK_HZ / 1_000_000)) / 1_000;

  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL       = 4'h0;
  localparam logic [3:0] OFF_SYS_DIV    = 4'h1;
  localparam logic [3:0] OFF_PER_DIV    = 4'h2;
  localparam logic [3:0] OFF_SYS_GATES  = 4'h3;
  localparam logic [3:0] OFF_PER_GATES  = 4'h4;
  localparam logic [3:0] OFF_RESET_CMD  = 4'h5;
  localparam logic [3:0] OFF_STATUS     = 4'h6;
  localparam logic [3:0] OFF_IRQ_STAT   = 4'h7;
  localparam logic [3:0] OFF_IRQ_MASK   = 4'h8;

  localparam int unsigned CTRL_DEEP     = 0;
  localparam int unsigned CTRL_ON_RET   = 1;
  localparam int unsigned CTRL_WAKE_IFO = 2;
  localparam int unsigned CTRL_SLOW_EN  = 3;
  localparam int unsigned CTRL_EXT_SRC  = 4;
  localparam logic [4:0]  CTRL_RESET    = 5'h08;

  localparam int unsigned CMD_CORE_RST  = 0;
  localparam int unsigned CMD_CHIP_RST  = 1;

  localparam int unsigned EV_SLEEP      = 0;
  localparam int unsigned EV_DEEP       = 1;
  localparam int unsigned EV_WAKE       = 2;
  localparam int unsigned EV_IGNORED    = 3;
  localparam int unsigned EV_W          = 4;

  localparam logic [7:0]  DIV_RESET     = 8'h00;
  localparam logic [15:0] GATES_RESET   = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_SLEEP  = 2'b01,
    MODE_DEEP   = 2'b11,
    MODE_WAKE   = 2'b10
  } mode_t;

  typedef struct packed {
    logic ext_pin_n;
    logic low_supply_detector;
    logic independent_watchdog;
    logic window_watchdog;
    logic sw_system_reset;
    logic core_stall_fault;
  } reset_src_t;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic fast_clk_en;
    logic slow_clk_en;
    logic fast_src_ext;
  } clk_ctrl_t;

endpackage
`default_nettype wire

// *** test/power_mode_reset_gating_checker.sv ***
// power_mode_checker: mode, clock gating and reset filtering assertions
// assumes it is bound to power_mode_reset_gating with its parameters
`default_nettype none
module power_mode_checker #(
  parameter int unsigned GATES_W     = 16,
  parameter int unsigned WAKE_CYCLES = 4
) (
  // clock, reset and inputs
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       clk_en_i,
  input wire logic [3:0]                 addr_i,
  input wire logic [31:0]                wdata_i,
  input wire logic                       wr_i,
  input wire logic                       low_power_req_i,
  input wire logic                       handler_return_i,
  input wire logic                       irq_pending_i,
  input wire power_mode_pkg::reset_src_t reset_src_i,
  // watched outputs
  input wire power_mode_pkg::clk_ctrl_t  clk_ctrl_o,
  input wire power_mode_pkg::mode_t      mode_o,
  input wire logic                       sys_clk_tick_o,
  input wire logic [GATES_W-1:0]         system_clock_gates_o,
  input wire logic                       core_reset_o,
  input wire logic                       chip_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic act = mode_o == power_mode_pkg::MODE_ACTIVE;
  wire logic slp = mode_o == power_mode_pkg::MODE_SLEEP;
  wire logic dp  = mode_o == power_mode_pkg::MODE_DEEP;
  wire logic wk  = mode_o == power_mode_pkg::MODE_WAKE;
  wire logic req = low_power_req_i || handler_return_i;
  wire logic cmd = clk_en_i && wr_i
    && addr_i == power_mode_pkg::OFF_RESET_CMD;
  wire logic always_src = !reset_src_i.ext_pin_n
    || reset_src_i.low_supply_detector || reset_src_i.independent_watchdog;
  wire logic qual = always_src || (reset_src_i.window_watchdog && !dp)
    || (act && (reset_src_i.sw_system_reset
    || reset_src_i.core_stall_fault || (cmd && wdata_i[1])));
  // cycles spent waking, frozen with the clock enable
  logic [7:0] wake_cnt;
  always_ff @(posedge clk_i)
    if (rst_i || !wk)
      wake_cnt <= 8'h00;
    else
      wake_cnt <= wake_cnt + 8'(clk_en_i);
  a_active_clocks_run: assert property (
    act |-> clk_ctrl_o.core_clk_en && clk_ctrl_o.periph_clk_en)
    else $error("clock stopped in active mode");
  a_sleep_core_stop: assert property (
    slp |-> !clk_ctrl_o.core_clk_en && clk_ctrl_o.periph_clk_en)
    else $error("wrong clocks in sleep");
  a_deep_fast_stop: assert property (
    dp |-> !clk_ctrl_o.core_clk_en && !clk_ctrl_o.fast_clk_en
    && !sys_clk_tick_o && system_clock_gates_o == '0)
    else $error("clock running in deep sleep");
  a_deep_slow_kept: assert property (
    dp && !$past(dp) |-> $stable(clk_ctrl_o.slow_clk_en))
    else $error("slow clock changed on deep entry");
  a_entry_on_request: assert property (
    (slp || dp) && $past(act) |-> $past(req))
    else $error("low power entered without request");
  a_irq_wakes: assert property (
    (slp || dp) && irq_pending_i && clk_en_i |=> wk)
    else $error("interrupt did not wake");
  a_wake_exact: assert property (
    act && $past(wk) |-> wake_cnt == WAKE_CYCLES)
    else $error("wake length wrong");
  a_wake_bound: assert property (
    wake_cnt <= WAKE_CYCLES)
    else $error("wake too long");
  a_core_rst_taken: assert property (
    cmd && wdata_i[0] && act |=> core_reset_o)
    else $error("core reset command lost");
  a_core_rst_only: assert property (
    core_reset_o && $past(clk_en_i) |-> $past(act))
    else $error("core reset outside active");
  a_any_mode_rst: assert property (
    always_src && clk_en_i |=> chip_reset_o)
    else $error("reset source not honoured");
  a_window_rst: assert property (
    reset_src_i.window_watchdog && !dp && clk_en_i |=> chip_reset_o)
    else $error("window watchdog reset lost");
  a_rst_filter: assert property (
    chip_reset_o && $past(clk_en_i) |-> $past(qual))
    else $error("chip reset without qualified source");
  c_sleep: cover property (act ##1 slp);
  c_deep: cover property (act ##1 dp);
  c_wake: cover property (wk ##1 act);
endmodule
bind power_mode_reset_gating power_mode_checker #(
  .GATES_W(GATES_W), .WAKE_CYCLES(WAKE_CYCLES)
) u_chk (.*);
`default_nettype wire

// *** test/core_model.sv ***
// core_model: stand-in for the core's low-power requests and interrupts
// assumes one-cycle commands from the bench, synchronous to clk_i
`default_nettype none
module core_model (
  // clock and commands
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [2:0]            go_i,
  input  wire power_mode_pkg::mode_t mode_i,
  // core side
  output logic                       low_power_req_o,
  output logic                       handler_return_o,
  output logic                       irq_pending_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic running = mode_i == power_mode_pkg::MODE_ACTIVE;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_power_req_o  <= 1'b0;
      handler_return_o <= 1'b0;
      irq_pending_o    <= 1'b0;
    end
    else
    begin
      // software requests come as one-cycle pulses
      low_power_req_o  <= go_i[0];
      handler_return_o <= go_i[1];
      // pending holds until the core runs again
      irq_pending_o    <= go_i[2] || (irq_pending_o && !running);
    end
  end
endmodule
`default_nettype wire

// *** test/test_power_mode_reset_gating.sv ***
// test_power_mode_reset_gating: random and corner tests of the block
// assumes the bound checker and core_model on the core side
`default_nettype none
module test_power_mode_reset_gating;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  RA [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6,
                                     4'h7, 4'hF};
  localparam logic [31:0] RV [8] = '{32'h8, 32'h0, 32'h0, 32'hFFFF,
                                     32'hFFFF, 32'h0, 32'h0, 32'h0};
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic [3:0]                addr_i = 4'h0;
  logic [31:0]               wdata_i = 32'h0;
  logic                      wr_i = 1'b0;
  logic                      rd_i = 1'b0;
  logic                      clk_en = 1'b1;
  logic [2:0]                go = 3'h0;
  power_mode_pkg::reset_src_t src = 6'h20;
  logic [31:0]               rdata_o;
  logic                      lp_req, h_ret, irq_pend, irq_o;
  logic                      sys_tick, per_tick, core_rst, chip_rst;
  power_mode_pkg::clk_ctrl_t clk_ctrl_o;
  power_mode_pkg::mode_t     mode_o;
  logic [15:0]               sys_gates, per_gates;
  int                        failures = 0;
  int                        compares = 0;
  int                        cycles = 0;
  logic [31:0]               d;
  always #12.5 clk_i = ~clk_i;
  power_mode_reset_gating #(.WAKE_CYCLES(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .low_power_req_i(lp_req), .handler_return_i(h_ret),
    .irq_pending_i(irq_pend), .reset_src_i(src), .clk_ctrl_o(clk_ctrl_o),
    .mode_o(mode_o), .sys_clk_tick_o(sys_tick), .per_clk_tick_o(per_tick),
    .system_clock_gates_o(sys_gates), .peripheral_clock_gates_o(per_gates),
    .core_reset_o(core_rst), .chip_reset_o(chip_rst), .irq_o(irq_o));
  core_model u_core (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .mode_i(mode_o),
    .low_power_req_o(lp_req), .handler_return_o(h_ret),
    .irq_pending_o(irq_pend));
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  task automatic cmd(int k);
    @(posedge clk_i);
    go <= 3'(1 << k);
    @(posedge clk_i);
    go <= 3'h0;
  endtask
  task automatic wait_mode(power_mode_pkg::mode_t m);
    int n;
    n = 0;
    while (mode_o !== m && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    check("mode", 32'(mode_o), 32'(m));
  endtask
  task automatic wake();
    cmd(2);
    wait_mode(power_mode_pkg::MODE_WAKE);
    wait_mode(power_mode_pkg::MODE_ACTIVE);
  endtask
  function automatic logic honoured(int i, int m);
    return i >= 3 || (i == 2 && m != 2) || m == 0;
  endfunction
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    int s;
    int m;
    int i;
    logic [7:0] dv;
    logic [15:0] g;
    s = $urandom(32'hA04B);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      rd(RA[i], d);
      check("reset value", d, RV[i]);
    end
    check("clock enables", 32'(clk_ctrl_o), 32'h1E);
    for (i = 1; i <= 2; i++)
    begin
      dv = 8'($urandom_range(7));
      wr(4'(i), {24'h0, dv});
      @(negedge clk_i);
      s = 0;
      repeat (8 * (dv + 1))
      begin
        s += i == 1 ? sys_tick : per_tick;
        @(negedge clk_i);
      end
      check("ticks", s, 8);
    end
    for (i = 0; i < 2; i++)
    begin
      g = i == 0 ? 16'h0000 : 16'($urandom);
      wr(power_mode_pkg::OFF_SYS_GATES, {16'h0, g});
      wr(power_mode_pkg::OFF_PER_GATES, {16'h0, ~g});
      @(negedge clk_i);
      check("gates", {sys_gates, per_gates}, {g, ~g});
    end
    for (m = 0; m < 3; m++)
    begin
      wr(power_mode_pkg::OFF_IRQ_MASK, m == 1 ? 32'h0 : 32'h8);
      if (m > 0)
      begin
        wr(power_mode_pkg::OFF_CTRL, m == 2 ? 32'h9 : 32'h8);
        cmd(0);
        wait_mode(m == 2 ? power_mode_pkg::MODE_DEEP
                         : power_mode_pkg::MODE_SLEEP);
        check("core clock", clk_ctrl_o.core_clk_en, 1'b0);
        check("fast clock", clk_ctrl_o.fast_clk_en, m == 1);
        check("slow clock", clk_ctrl_o.slow_clk_en, 1'b1);
      end
      for (i = 0; i < 6; i++)
      begin
        @(posedge clk_i);
        src <= 6'h20 ^ (6'h1 << i);
        @(posedge clk_i);
        src <= 6'h20;
        @(negedge clk_i);
        check("chip reset", chip_rst, honoured(i, m));
      end
      wr(power_mode_pkg::OFF_RESET_CMD, 32'h1);
      @(negedge clk_i);
      check("core reset", core_rst, m == 0);
      wr(power_mode_pkg::OFF_RESET_CMD, 32'h2);
      @(negedge clk_i);
      check("chip command", chip_rst, m == 0);
      rd(power_mode_pkg::OFF_IRQ_STAT, d);
      check("ignored flag", d & 32'h8, m == 0 ? 32'h0 : 32'h8);
      check("irq", irq_o, m == 2);
      wr(power_mode_pkg::OFF_IRQ_STAT, 32'hF);
      @(negedge clk_i);
      check("irq cleared", irq_o, 1'b0);
      if (m > 0)
        wake();
    end
    for (i = 0; i < 2; i++)
    begin
      wr(power_mode_pkg::OFF_CTRL, i == 0 ? 32'h1D : 32'h19);
      cmd(0);
      wait_mode(power_mode_pkg::MODE_DEEP);
      wake();
      check("fast source", clk_ctrl_o.fast_src_ext, i == 1);
    end
    wr(power_mode_pkg::OFF_CTRL, 32'hB);
    cmd(1);
    wait_mode(power_mode_pkg::MODE_DEEP);
    // interrupt arrives while the clock enable freezes the block
    @(posedge clk_i);
    clk_en <= 1'b0;
    cmd(2);
    repeat (3) @(negedge clk_i);
    check("frozen mode", 32'(mode_o), 32'(power_mode_pkg::MODE_DEEP));
    @(posedge clk_i);
    clk_en <= 1'b1;
    wait_mode(power_mode_pkg::MODE_WAKE);
    wait_mode(power_mode_pkg::MODE_ACTIVE);
    conclude();
  end
endmodule
`default_nettype wire
